// ---- core/port_expander.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "expander_cfg.svh"
module port_expander #(
	parameter logic [`ADDR_HIGH_W-1:0] ADDR_HIGH = `ADDR_HIGH_DEFAULT,
	parameter int PORT_WIDTH = `PORT_WIDTH
) (
	input wire logic clk_in, // core clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive level
	output logic sda_oe_out, // serial data pull-low enable
	input wire logic addr_pin_0_in, // address strap 0
	input wire logic addr_pin_1_in, // address strap 1
	input wire logic addr_pin_2_in, // address strap 2
	input wire logic [PORT_WIDTH-1:0] port_in, // port pin levels
	output logic [PORT_WIDTH-1:0] port_out, // port drive levels
	output logic [PORT_WIDTH-1:0] port_oe_out, // port strong drive
	output logic alert_n_out, // change alert level
	output logic alert_n_oe_out // change alert pull-low enable
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (PORT_WIDTH != `PORT_WIDTH)
	begin : g_width_check
		$error("port width must match the serial byte");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// a line counts as input only while its latch is high
	function automatic logic input_changed(
		input logic [PORT_WIDTH-1:0] levels,
		input logic [PORT_WIDTH-1:0] ref_levels,
		input logic [PORT_WIDTH-1:0] latch
	);
		input_changed = |((levels ^ ref_levels) & latch);
	endfunction

	function automatic logic fell(input logic prev, input logic now);
		fell = prev & ~now;
	endfunction

	// ----------------------------------------------------------------
	// link domain
	// ----------------------------------------------------------------
	bit_link_if link ();

	scl_bit_sampler u_sampler (
		.scl_in(scl_in),
		.rst_n_in(rst_n_in),
		.sda_in(sda_in),
		.link(link)
	);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic scl_meta, scl_sync, scl_prev;
	logic sda_meta, sda_sync, sda_prev;
	logic tog_meta, tog_sync, tog_prev;
	logic [PORT_WIDTH-1:0] port_meta, port_sync;
	logic [`ADDR_LOW_W-1:0] addr_meta, addr_sync;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_meta <= `LINE_IDLE;
			scl_sync <= `LINE_IDLE;
			scl_prev <= `LINE_IDLE;
			sda_meta <= `LINE_IDLE;
			sda_sync <= `LINE_IDLE;
			sda_prev <= `LINE_IDLE;
		end
		else
		begin
			scl_meta <= scl_in;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_prev <= 1'b0;
		end
		else
		begin
			tog_meta <= link.bit_toggle;
			tog_sync <= tog_meta;
			tog_prev <= tog_sync;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			port_meta <= `PORT_RESET;
			port_sync <= `PORT_RESET;
			addr_meta <= '0;
			addr_sync <= '0;
		end
		else
		begin
			port_meta <= port_in;
			port_sync <= port_meta;
			addr_meta <= {addr_pin_2_in, addr_pin_1_in, addr_pin_0_in};
			addr_sync <= addr_meta;
		end
	end

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	logic start_cond, stop_cond, scl_fall, bit_evt;

	assign start_cond = scl_sync & scl_prev & fell(sda_prev, sda_sync);
	assign stop_cond = scl_sync & scl_prev & fell(sda_sync, sda_prev);
	assign scl_fall = fell(scl_prev, scl_sync);
	assign bit_evt = tog_sync ^ tog_prev;

	// ----------------------------------------------------------------
	// serial slave
	// ----------------------------------------------------------------
	expander_pkg::slave_state_t state;
	logic [`BIT_CNT_W-1:0] bit_cnt;
	logic [PORT_WIDTH-1:0] rx_shift;
	logic [PORT_WIDTH-1:0] tx_shift;
	logic master_ack;
	logic sda_drive;
	logic byte_full, addr_match, wr_commit, rd_clear;

	assign byte_full = (bit_cnt == `BYTE_BITS);
	assign addr_match =
		(rx_shift[PORT_WIDTH-1:1] == {ADDR_HIGH, addr_sync});
	// a foreign address never reaches these states
	assign wr_commit = (state == expander_pkg::ST_WR_ACK) && scl_fall;
	assign rd_clear = (state == expander_pkg::ST_RD_ACK) && bit_evt;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= expander_pkg::ST_IDLE;
			bit_cnt <= `BIT_CNT_ZERO;
			rx_shift <= `PORT_ALL_LOW;
			tx_shift <= `PORT_RESET;
			master_ack <= 1'b0;
			sda_drive <= 1'b0;
		end
		else if (stop_cond)
		begin
			state <= expander_pkg::ST_IDLE;
			sda_drive <= 1'b0;
		end
		else if (start_cond)
		begin
			state <= expander_pkg::ST_ADDR;
			bit_cnt <= `BIT_CNT_ZERO;
			sda_drive <= 1'b0;
		end
		else
		begin
			unique case (state)
				expander_pkg::ST_IDLE:
				begin
					sda_drive <= 1'b0;
				end
				expander_pkg::ST_ADDR, expander_pkg::ST_WR_DATA:
				begin
					if (bit_evt && !byte_full)
					begin
						// msb arrives first
						rx_shift <= {rx_shift[PORT_WIDTH-2:0], link.bit_value};
						bit_cnt <= bit_cnt + `BIT_CNT_ONE;
					end
					else if (scl_fall && byte_full)
					begin
						if (state == expander_pkg::ST_WR_DATA)
						begin
							sda_drive <= 1'b1;
							state <= expander_pkg::ST_WR_ACK;
						end
						else if (addr_match)
						begin
							sda_drive <= 1'b1;
							state <= expander_pkg::ST_ADDR_ACK;
						end
						else
						begin
							state <= expander_pkg::ST_IDLE;
						end
					end
				end
				expander_pkg::ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						bit_cnt <= `BIT_CNT_ZERO;
						if (rx_shift[`RW_BIT])
						begin
							// current levels go out, msb first
							sda_drive <= ~port_sync[PORT_WIDTH-1];
							tx_shift <= {port_sync[PORT_WIDTH-2:0], `LINE_IDLE};
							state <= expander_pkg::ST_RD_DATA;
						end
						else
						begin
							sda_drive <= 1'b0;
							state <= expander_pkg::ST_WR_DATA;
						end
					end
				end
				expander_pkg::ST_WR_ACK:
				begin
					if (scl_fall)
					begin
						sda_drive <= 1'b0;
						bit_cnt <= `BIT_CNT_ZERO;
						state <= expander_pkg::ST_WR_DATA;
					end
				end
				expander_pkg::ST_RD_DATA:
				begin
					if (bit_evt && !byte_full)
					begin
						bit_cnt <= bit_cnt + `BIT_CNT_ONE;
					end
					else if (scl_fall && byte_full)
					begin
						sda_drive <= 1'b0;
						state <= expander_pkg::ST_RD_ACK;
					end
					else if (scl_fall)
					begin
						sda_drive <= ~tx_shift[PORT_WIDTH-1];
						tx_shift <= {tx_shift[PORT_WIDTH-2:0], `LINE_IDLE};
					end
				end
				expander_pkg::ST_RD_ACK:
				begin
					if (bit_evt)
					begin
						master_ack <= ~link.bit_value;
					end
					else if (scl_fall && master_ack)
					begin
						bit_cnt <= `BIT_CNT_ZERO;
						sda_drive <= ~port_sync[PORT_WIDTH-1];
						tx_shift <= {port_sync[PORT_WIDTH-2:0], `LINE_IDLE};
						state <= expander_pkg::ST_RD_DATA;
					end
					else if (scl_fall)
					begin
						// master refused: stay off the bus until the next start
						state <= expander_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// serial data pin
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sda_out <= `LINE_LOW;
			sda_oe_out <= 1'b0;
		end
		else
		begin
			sda_out <= `LINE_LOW;
			sda_oe_out <= sda_drive;
		end
	end

	// ----------------------------------------------------------------
	// quasi-bidirectional port
	// ----------------------------------------------------------------
	// no direction register: a high latch is an input
	logic [PORT_WIDTH-1:0] port_latch;
	logic [PORT_WIDTH-1:0] strong_pu;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			port_latch <= `PORT_RESET;
			strong_pu <= `PORT_ALL_LOW;
		end
		else if (wr_commit)
		begin
			port_latch <= rx_shift;
			strong_pu <= rx_shift;
		end
		else if (scl_fall)
		begin
			strong_pu <= `PORT_ALL_LOW;
		end
	end

	// low lines are driven hard; high lines only while boosted
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			port_out <= `PORT_RESET;
			port_oe_out <= `PORT_ALL_LOW;
		end
		else
		begin
			port_out <= port_latch;
			port_oe_out <= ~port_latch | strong_pu;
		end
	end

	// ----------------------------------------------------------------
	// change alert
	// ----------------------------------------------------------------
	logic [PORT_WIDTH-1:0] ref_levels;
	logic [`SETTLE_W-1:0] settle;
	logic next_alert;

	// freshly written lines need drive plus sync time to read back;
	// without this hold-off a line written high would flash the alert
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			settle <= `SETTLE_ZERO;
		end
		else if (wr_commit)
		begin
			settle <= `SETTLE_CYCLES;
		end
		else if (settle != `SETTLE_ZERO)
		begin
			settle <= settle - `SETTLE_ONE;
		end
	end

	// comparing against a snapshot also clears when lines return
	assign next_alert = input_changed(port_sync, ref_levels, port_latch);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ref_levels <= `PORT_RESET;
		end
		else if (wr_commit)
		begin
			// new written levels, so a released line does not alert
			ref_levels <= rx_shift;
		end
		else if (rd_clear)
		begin
			// a change in this very cycle is absorbed
			ref_levels <= port_sync;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			alert_n_out <= `LINE_IDLE;
			alert_n_oe_out <= 1'b0;
		end
		else
		begin
			// one cycle after detection, far inside the valid delay
			alert_n_out <= ~(next_alert && settle == `SETTLE_ZERO);
			alert_n_oe_out <= next_alert && settle == `SETTLE_ZERO;
		end
	end

endmodule // port_expander
`default_nettype wire

// ---- core/scl_bit_sampler.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "expander_cfg.svh"
module scl_bit_sampler (
	input wire logic scl_in, // serial clock, link domain
	input wire logic rst_n_in, // async reset, active low
	input wire logic sda_in, // serial data level
	bit_link_if.sampler link // sampled bit towards core
);

	// ----------------------------------------------------------------
	// bit capture on the serial clock
	// ----------------------------------------------------------------
	// value is held a whole serial period, so the core may read it
	// once the toggle has crossed; no word needs gray coding
	always_ff @(posedge scl_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			link.bit_toggle <= 1'b0;
			link.bit_value <= `LINE_IDLE;
		end
		else
		begin
			link.bit_toggle <= ~link.bit_toggle;
			link.bit_value <= sda_in;
		end
	end

endmodule // scl_bit_sampler
`default_nettype wire

// ---- shared/bit_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface bit_link_if;
	logic bit_toggle;
	logic bit_value;

	modport sampler (output bit_toggle, output bit_value);
	modport core (input bit_toggle, input bit_value);
endinterface : bit_link_if
`default_nettype wire

// ---- shared/expander_cfg.svh ----
// Notes on behaviour
// - every line is input or output independently
// - direction follows last written level only
// - read returns current port line levels
// - written data byte is latched onto lines
// - change alert output is open-drain
// - any edge on input line raises alert
// - levels back to original clear the alert
// - read or write of port clears alert
// - read clears alert at acknowledge rising edge
// - write clears alert at acknowledge falling edge
// - changes during acknowledge pulse may be lost
// - later changes alert after next clock edge
// - traffic for other addresses leaves alert alone
// - power-up lines high, weak pull-up only
// - writing high turns on strong pull-up
// - strong pull-up off at next clock fall
// - change alert is active low
// - alert valid within bounded delay of change
// - reset clears bus logic, lines to one
// - three pins give low slave address bits
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

// ----------------------------------------------------------------
// port and byte layout
// ----------------------------------------------------------------
`define PORT_WIDTH 8
`define PORT_RESET 8'hFF
`define PORT_ALL_LOW 8'h00
`define BIT_CNT_W 4
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_ONE 4'h1
`define BYTE_BITS 4'h8
`define RW_BIT 0
`define ADDR_LOW_W 3
`define ADDR_HIGH_W 4
// arbitrary neutral value for the fixed upper address bits
`define ADDR_HIGH_DEFAULT 4'h5

// ----------------------------------------------------------------
// synchroniser and line levels
// ----------------------------------------------------------------
`define SYNC_STAGES 2
`define LINE_IDLE 1'b1
`define LINE_LOW 1'b0
`define SETTLE_W 2
`define SETTLE_CYCLES 2'h3
`define SETTLE_ZERO 2'h0
`define SETTLE_ONE 2'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define ALERT_VALID_DELAY_NS 4000
`define ALERT_VALID_CYCLES (`ALERT_VALID_DELAY_NS / `CLK_PERIOD_NS)

`endif

// ---- shared/expander_pkg.sv ----
`default_nettype none
package expander_pkg;

	// ----------------------------------------------------------------
	// serial slave states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_DATA,
		ST_WR_ACK,
		ST_RD_DATA,
		ST_RD_ACK
	} slave_state_t;

endpackage : expander_pkg
`default_nettype wire

// ---- sim/bus_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bus_master_model #(
	parameter int HALF_NS = 82
) (
	input wire logic sda_in, // data line
	output logic scl_out, // bus clock
	output logic sda_low_out // pulls data low
);
	// ----------------------------------------------------------
	// framing; the clock stands still between frames
	// ----------------------------------------------------------
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	task automatic start_cond();
		sda_low_out = 1'b1;
		#(HALF_NS);
		scl_out = 1'b0;
	endtask

	// odd quarter period keeps the phase drifting against the core clock
	task automatic clock_bit(input logic drive, output logic seen);
		sda_low_out = !drive;
		#(HALF_NS / 2);
		scl_out = 1'b1;
		#(HALF_NS / 2);
		seen = sda_in;
		#(HALF_NS / 2);
		scl_out = 1'b0;
		#(HALF_NS / 2);
	endtask

	task automatic write_byte(input logic [7:0] data, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clock_bit(data[i], seen);
		clock_bit(1'b1, seen);
		ack = !seen;
	endtask

	task automatic read_byte(input logic last, output logic [7:0] data);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clock_bit(1'b1, data[i]);
		clock_bit(last, seen);
	endtask

	task automatic stop_cond();
		sda_low_out = 1'b1;
		#(HALF_NS / 2);
		scl_out = 1'b1;
		#(HALF_NS);
		sda_low_out = 1'b0;
		#(HALF_NS);
	endtask
endmodule // bus_master_model
`default_nettype wire

// ---- sim/port_expander_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module port_expander_asserts #(
	parameter int PORT_WIDTH = 8
) (
	input wire logic clk_in, // clock
	input wire logic rst_n_in, // reset
	input wire logic scl_in, // bus clock
	input wire logic sda_in, // bus data
	input wire logic sda_oe_out, // data pull
	input wire logic [PORT_WIDTH-1:0] port_in, // pins
	input wire logic [PORT_WIDTH-1:0] port_out, // latch
	input wire logic [PORT_WIDTH-1:0] port_oe_out, // drive
	input wire logic alert_n_out, // alert
	input wire logic alert_n_oe_out // alert pull
);
	// ----------------------------------------------------------
	// port, alert and bus side properties
	// ----------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_alert_level:
	assert property (alert_n_out == !alert_n_oe_out)
	else $error("alert level wrong");
	chk_reset_vals:
	assert property ($rose(rst_n_in) |-> port_out == '1 && port_oe_out == '0
		&& !alert_n_oe_out && !sda_oe_out)
	else $error("reset values wrong");
	// bus kept quiet so no clear can hide the change
	chk_alert_rise:
	assert property (!alert_n_oe_out && $changed(port_in & port_out)
		##1 ($stable(port_in) && scl_in && sda_in) [*5] |-> alert_n_oe_out)
	else $error("alert missing");
	chk_strong_off:
	assert property ((port_oe_out & port_out) != '0 && $fell(scl_in)
		|-> ##[1:8] (port_oe_out & port_out) == '0)
	else $error("strong pull-up stays on");
	chk_low_driven:
	assert property ((port_oe_out | port_out) == '1)
	else $error("low line not driven");
	chk_sda_edge:
	assert property ($changed(sda_oe_out) |-> !scl_in)
	else $error("data moved with clock high");
	chk_ack_hold:
	assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
	else $error("data pull too short");
	chk_port_hold:
	assert property ($changed(port_out) |-> !scl_in)
	else $error("latch moved with clock high");
endmodule // port_expander_asserts

bind port_expander port_expander_asserts #(.PORT_WIDTH(PORT_WIDTH)) chk_u (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
	.sda_in(sda_in), .sda_oe_out(sda_oe_out), .port_in(port_in),
	.port_out(port_out), .port_oe_out(port_oe_out),
	.alert_n_out(alert_n_out), .alert_n_oe_out(alert_n_oe_out)
);
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic scl;
	logic m_low;
	logic sda_oe;
	logic sda_line;
	logic [2:0] straps = 3'b101;
	logic [7:0] ext_low = 8'h00;
	logic [7:0] pins;
	logic [7:0] p_out;
	logic [7:0] p_oe;
	logic alert_n;
	logic alert_oe;
	logic ack;
	logic [7:0] rd;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;

	// ----------------------------------------------------------
	// wiring; released lines go to their pull-up level
	// ----------------------------------------------------------
	always #2 clk_in = ~clk_in;
	assign sda_line = ~(sda_oe | m_low);
	// a low from either side wins; the boost cannot hold off a driver
	assign pins = ~((p_oe & ~p_out) | ext_low);

	bus_master_model m_u (.sda_in(sda_line), .scl_out(scl),
		.sda_low_out(m_low));
	port_expander dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
		.addr_pin_0_in(straps[0]), .addr_pin_1_in(straps[1]),
		.addr_pin_2_in(straps[2]), .port_in(pins), .port_out(p_out),
		.port_oe_out(p_oe), .alert_n_out(alert_n),
		.alert_n_oe_out(alert_oe));

	task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic check_bit(string what, logic exp, logic got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s exp %b got %b", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// pins change only while the bus is idle
	task automatic set_ext(logic [7:0] v);
		@(negedge clk_in);
		ext_low = v;
		repeat (8) @(negedge clk_in);
	endtask

	task automatic bus_write(logic [6:0] a, logic [7:0] d);
		logic ak;
		m_u.start_cond();
		m_u.write_byte({a, 1'b0}, ack);
		if (ack)
			m_u.write_byte(d, ak);
		m_u.stop_cond();
	endtask

	task automatic bus_read(logic [6:0] a);
		m_u.start_cond();
		m_u.write_byte({a, 1'b1}, ack);
		if (ack)
			m_u.read_byte(1'b1, rd);
		m_u.stop_cond();
	endtask

	task automatic t_write();
		bus_write(7'h2D, 8'hA5);
		check_bit("ack", 1'b1, ack);
		check_byte("port_out", 8'hA5, p_out);
		check_byte("port_oe", 8'hFF, p_oe);
		bus_write(7'h2D, 8'hFF);
	endtask

	task automatic t_read();
		set_ext(8'h81);
		check_bit("alert_n", 1'b0, alert_n);
		check_bit("alert_oe", 1'b1, alert_oe);
		bus_read(7'h2D);
		check_byte("read", 8'h7E, rd);
		check_byte("port_oe", 8'h00, p_oe);
		check_bit("alert_n", 1'b1, alert_n);
	endtask

	task automatic t_back();
		set_ext(8'h00);
		check_bit("alert_n", 1'b0, alert_n);
		set_ext(8'h81);
		check_bit("alert_n", 1'b1, alert_n);
	endtask

	task automatic t_wclear();
		set_ext(8'h00);
		bus_write(7'h2D, 8'hFF);
		check_bit("alert_n", 1'b1, alert_n);
	endtask

	task automatic t_other();
		set_ext(8'h10);
		bus_write(7'h2C, 8'h00);
		check_bit("ack", 1'b0, ack);
		check_byte("port_out", 8'hFF, p_out);
		check_bit("alert_n", 1'b0, alert_n);
		@(negedge clk_in);
		straps = 3'b100;
		bus_read(7'h2C);
		check_bit("ack", 1'b1, ack);
		check_byte("read", 8'hEF, rd);
	endtask

	task automatic t_mixed();
		bus_write(7'h2C, 8'h0F);
		set_ext(8'h11);
		bus_read(7'h2C);
		check_byte("read", 8'h0E, rd);
		check_byte("port_oe", 8'hF0, p_oe);
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (16) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (8) @(negedge clk_in);
		check_byte("port_out", 8'hFF, p_out);
		check_bit("alert_n", 1'b1, alert_n);
		#1.3;
		t_write();
		t_read();
		t_back();
		t_wclear();
		t_other();
		t_mixed();
		print_verdict();
	end
endmodule // tb
`default_nettype wire
